// [design/pdc_device.sv]
// Synthesizer configuration logic: pin capture, serial load, dividers
`timescale 1ns/1ps
module pdc_device
   import pdc_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   pdc_link_if.device link,
   input wire logic i_external_reference_in,
   input wire logic i_vco_clk,
   output logic o_synth_clock_out,
   output logic o_cmp_ref,
   output logic o_fb_ref,
   output logic o_monitor,
   output logic [M_W-1:0] o_m_active,
   output logic [N_W-1:0] o_n_active,
   output logic [T_W-1:0] o_t_active
);
   // ***********************
   // Input synchronisers
   // ***********************
   localparam int unsigned SW = 6 + M_W + N_W;
   // Reset to idle pin levels: a mismatch would fake a strobe edge after reset
   localparam logic [SW-1:0] SYNC_RST = {6'h00, {(M_W + N_W){1'b1}}};
   logic [SW-1:0] raw; // All asynchronous inputs
   logic [SW-1:0] meta; // First stage, read only by second
   logic [SW-1:0] sync; // Second stage, safe to use
   logic [SW-1:0] last; // Previous value for edge finding

   assign raw = {i_external_reference_in, i_vco_clk, link.s_clock,
                 link.s_data, link.s_load, link.p_load_n,
                 link.m_pin, link.n_pin};

   // Two flops per bit, then a third for edges
   genvar gi;
   generate
      for (gi = 0; gi < SW; gi++)
      begin : g_sync
         always_ff @(posedge i_mclk)
         begin
            if (i_rst)
            begin
               meta[gi] <= SYNC_RST[gi];
               sync[gi] <= SYNC_RST[gi];
               last[gi] <= SYNC_RST[gi];
            end
            else if (i_ce)
            begin
               meta[gi] <= raw[gi];
               sync[gi] <= meta[gi];
               last[gi] <= sync[gi];
            end
         end
      end
   endgenerate

   // Named views of synchronised inputs
   logic ref_lvl;
   logic vco_lvl;
   logic sclk_lvl;
   logic sdata_lvl;
   logic [M_W-1:0] m_pins;
   logic [N_W-1:0] n_pins;
   logic ref_rise;
   logic vco_rise;
   logic sclk_rise;
   logic sload_fall;
   logic pload_rise;
   logic pload_low;
   assign ref_lvl = sync[SW-1];
   assign vco_lvl = sync[SW-2];
   assign sclk_lvl = sync[SW-3];
   assign sdata_lvl = sync[SW-4];
   assign pload_low = ~sync[SW-6];
   assign m_pins = sync[N_W +: M_W];
   assign n_pins = sync[0 +: N_W];
   assign ref_rise = sync[SW-1] & ~last[SW-1];
   assign vco_rise = sync[SW-2] & ~last[SW-2];
   assign sclk_rise = sync[SW-3] & ~last[SW-3];
   assign sload_fall = ~sync[SW-5] & last[SW-5];
   assign pload_rise = sync[SW-6] & ~last[SW-6];

   // ***********************
   // Configuration latches
   // ***********************
   logic [SR_W-1:0] sreg; // Serial shift register
   logic [SR_W-1:0] next_sreg;
   logic [M_W-1:0] cfg_m; // Held loop divider
   logic [M_W-1:0] next_cfg_m;
   logic [N_W-1:0] cfg_n; // Held output select
   logic [N_W-1:0] next_cfg_n;
   logic [T_W-1:0] cfg_t; // Held monitor select
   logic [T_W-1:0] next_cfg_t;

   // Parallel path first, serial path only with load high
   always_comb
   begin
      next_sreg = sreg;
      next_cfg_m = cfg_m;
      next_cfg_n = cfg_n;
      next_cfg_t = cfg_t;
      if (pload_low)
      begin
         next_cfg_t = T_RST;
         next_cfg_m = m_pins;
         next_cfg_n = n_pins;
      end
      else if (pload_rise)
      begin
         next_cfg_m = m_pins;
         next_cfg_n = n_pins;
      end
      else
      begin
         if (sclk_rise)
            next_sreg = {sreg[SR_W-2:0], sdata_lvl};
         if (sload_fall)
         begin
            next_cfg_t = sreg[SR_T_LSB +: T_W];
            next_cfg_n = sreg[SR_N_LSB +: N_W];
            next_cfg_m = sreg[0 +: M_W];
         end
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         sreg <= '0;
         cfg_m <= M_RST;
         cfg_n <= N_RST;
         cfg_t <= T_RST;
      end
      else if (i_ce)
      begin
         sreg <= next_sreg;
         cfg_m <= next_cfg_m;
         cfg_n <= next_cfg_n;
         cfg_t <= next_cfg_t;
      end
   end

   // Transparent view costs no extra cycle
   logic [M_W-1:0] m_eff;
   logic [N_W-1:0] n_eff;
   logic [T_W-1:0] t_eff;
   assign m_eff = pload_low ? m_pins : cfg_m;
   assign n_eff = pload_low ? n_pins : cfg_n;
   assign t_eff = pload_low ? T_RST : cfg_t;

   // ***********************
   // Reference and feedback dividers
   // ***********************
   logic [PRE_W-1:0] pre_cnt; // Reference prescaler
   logic [PRE_W-1:0] next_pre_cnt;
   logic [M_W-1:0] fb_cnt; // Loop divider count
   logic [M_W-1:0] next_fb_cnt;
   logic fb_q; // Feedback square wave
   logic next_fb_q;
   logic mon_q; // Registered monitor pin
   logic next_mon_q;
   logic synth_clk; // Divided output clock

   // Counts edges; top bit gives a square wave
   always_comb
   begin
      next_pre_cnt = ref_rise ? pre_cnt + 1'b1 : pre_cnt;
      next_fb_cnt = fb_cnt;
      next_fb_q = fb_q;
      // Toggle every M edges, period 2M
      if (vco_rise)
      begin
         if (fb_cnt + 9'h001 >= m_eff)
         begin
            next_fb_cnt = 9'h000;
            next_fb_q = ~fb_q;
         end
         else
            next_fb_cnt = fb_cnt + 9'h001;
      end
      // Monitor select; zero keeps it quiet
      case (t_eff)
         3'h0: next_mon_q = 1'b0;
         3'h1: next_mon_q = pre_cnt[PRE_W-1];
         3'h2: next_mon_q = fb_q;
         3'h3: next_mon_q = synth_clk;
         3'h4: next_mon_q = vco_lvl;
         3'h5: next_mon_q = ref_lvl;
         3'h6: next_mon_q = sclk_lvl;
         3'h7: next_mon_q = sreg[SR_W-1];
         default: next_mon_q = 1'b0;
      endcase
   end

   // Divider registers
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         pre_cnt <= '0;
         fb_cnt <= 9'h000;
         fb_q <= 1'b0;
         mon_q <= 1'b0;
      end
      else if (i_ce)
      begin
         pre_cnt <= next_pre_cnt;
         fb_cnt <= next_fb_cnt;
         fb_q <= next_fb_q;
         mon_q <= next_mon_q;
      end
   end

   pdc_out_div u_out_div (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_vco_lvl(vco_lvl),
      .i_vco_rise(vco_rise),
      .i_sel(n_eff),
      .o_clk(synth_clk)
   );

   assign o_synth_clock_out = synth_clk;
   assign o_cmp_ref = pre_cnt[PRE_W-1];
   assign o_fb_ref = fb_q;
   assign o_monitor = mon_q;
   assign o_m_active = cfg_m;
   assign o_n_active = cfg_n;
   assign o_t_active = cfg_t;
endmodule // pdc_device

// [design/pdc_pkg.sv]
// Shared constants for the divider configuration loader and its controller
package pdc_pkg;
   // ***********************
   // Clock and link timing
   // ***********************
   localparam int unsigned MCLK_HZ = 40_000_000;
   localparam int unsigned MCLK_PS = 25_000;
   // Fastest shift clock for divider loads
   localparam int unsigned SCLK_MAX_HZ = 10_000_000;
   // Half period, rounded up so the rate stays at or below the limit
   localparam int unsigned SCLK_HALF_CYC =
      (MCLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
   // Least strobe width, both load strobes
   localparam int unsigned LOAD_PW_NS = 50;
   localparam int unsigned LOAD_PW_CYC = (LOAD_PW_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
   // Least setup and hold of pins around the strobes
   localparam int unsigned PIN_SH_NS = 20;
   localparam int unsigned PIN_SH_CYC = (PIN_SH_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
   // ***********************
   // Field widths and codes
   // ***********************
   localparam int unsigned M_W = 9;
   localparam int unsigned N_W = 2;
   localparam int unsigned T_W = 3;
   localparam int unsigned SR_W = 14;
   localparam int unsigned SR_T_LSB = 11;
   localparam int unsigned SR_N_LSB = 9;
   localparam int unsigned REF_PRESCALE = 16;
   localparam int unsigned PRE_W = $clog2(REF_PRESCALE);
   localparam logic [N_W-1:0] N_DIV1 = 2'h3;
   localparam logic [N_W-1:0] N_DIV2 = 2'h0;
   localparam logic [N_W-1:0] N_DIV4 = 2'h1;
   localparam logic [N_W-1:0] N_DIV8 = 2'h2;
   // Reset values match floating pulled-up pins
   localparam logic [M_W-1:0] M_RST = 9'h1FF;
   localparam logic [N_W-1:0] N_RST = 2'h3;
   localparam logic [T_W-1:0] T_RST = 3'h0;
   // ***********************
   // Controller register map
   // ***********************
   localparam int unsigned AW = 8;
   localparam logic [AW-1:0] REG_CMD = 8'h00;
   localparam logic [AW-1:0] REG_CFG = 8'h04;
   localparam logic [AW-1:0] REG_PIN = 8'h08;
   localparam logic [AW-1:0] REG_STAT = 8'h0C;
   localparam int unsigned CMD_SER_BIT = 0;
   localparam int unsigned CMD_PAR_BIT = 1;
   localparam int unsigned CFG_M_LSB = 0;
   localparam int unsigned CFG_N_LSB = 9;
   localparam int unsigned CFG_T_LSB = 11;
   localparam int unsigned PIN_OE_BIT = 0;
   localparam int unsigned STAT_BUSY_BIT = 0;
   localparam int unsigned STAT_PLOAD_BIT = 1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [design/pdc_link_if.sv]
// Pin-level link between configuration controller and synthesizer logic
`timescale 1ns/1ps
interface pdc_link_if;
   import pdc_pkg::*;
   logic s_clock;
   logic s_data;
   logic s_load;
   logic p_load_n;
   logic [M_W-1:0] m_drv;
   logic [N_W-1:0] n_drv;
   logic par_oe;
   logic [M_W-1:0] m_pin;
   logic [N_W-1:0] n_pin;
   // Pull-ups: an undriven divider pin reads high
   assign m_pin = par_oe ? m_drv : '1;
   assign n_pin = par_oe ? n_drv : '1;
   modport device (
      input s_clock, s_data, s_load, p_load_n, m_pin, n_pin
   );
   modport host (
      output s_clock, s_data, s_load, p_load_n, m_drv, n_drv, par_oe
   );
endinterface // pdc_link_if

// [design/pdc_out_div.sv]
// Output divider with 50% duty at every ratio
`timescale 1ns/1ps
module pdc_out_div
   import pdc_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_vco_lvl,
   input wire logic i_vco_rise,
   input wire logic [N_W-1:0] i_sel,
   output logic o_clk
);
   // ***********************
   // Synchronous count of oscillator edges
   // ***********************
   logic [2:0] cnt; // Rising edge count
   logic [2:0] next_cnt;
   logic out_q; // Registered divided clock
   logic next_out_q;

   // Each counter bit toggles at half its rate, hence square
   always_comb
   begin
      next_cnt = i_vco_rise ? cnt + 3'h1 : cnt;
      case (i_sel)
         N_DIV1: next_out_q = i_vco_lvl; // Pass straight through
         N_DIV2: next_out_q = next_cnt[0];
         N_DIV4: next_out_q = next_cnt[1];
         N_DIV8: next_out_q = next_cnt[2];
         default: next_out_q = i_vco_lvl;
      endcase
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         cnt <= 3'h0;
         out_q <= 1'b0;
      end
      else if (i_ce)
      begin
         cnt <= next_cnt;
         out_q <= next_out_q;
      end
   end

   assign o_clk = out_q;
endmodule // pdc_out_div

// [design/pdc_host.sv]
// Configuration controller: AXI4-Lite registers driving the link pins
`timescale 1ns/1ps
module pdc_host
   import pdc_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   pdc_link_if.host link,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [AW-1:0] i_awaddr,
   input wire logic i_wvalid,
   output logic o_wready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   output logic o_bvalid,
   input wire logic i_bready,
   output logic [1:0] o_bresp,
   input wire logic i_arvalid,
   output logic o_arready,
   input wire logic [AW-1:0] i_araddr,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp
);
   typedef enum {H_IDLE, H_PLOW, H_PHOLD, H_SLOW, H_SHIGH, H_SLOAD, H_SEND} pdc_hst_t;
   // ***********************
   // State
   // ***********************
   pdc_hst_t st, next_st; // Link sequencer
   logic [3:0] cnt, next_cnt; // Phase timer
   logic [3:0] bit_i, next_bit_i; // Bits left to send
   logic [SR_W-1:0] cfg, next_cfg; // Word to load
   logic pin_oe, next_pin_oe; // Keep pins driven when idle
   logic aw_h, next_aw_h, w_h, next_w_h; // Write halves held
   logic [AW-1:0] wa, next_wa;
   logic [31:0] wd, next_wd;
   logic bv, next_bv, wr_bad, next_wr_bad;
   logic rv, next_rv;
   logic [31:0] rd, next_rd;
   logic [1:0] rr, next_rr;
   logic sck, next_sck, sd, next_sd, sl, next_sl, pl, next_pl, oe, next_oe;
   logic do_wr;

   assign do_wr = aw_h & w_h & ~bv;

   // Bus slave and sequencer; commands while busy are dropped
   always_comb
   begin
      next_st = st; next_cnt = cnt; next_bit_i = bit_i; next_cfg = cfg;
      next_pin_oe = pin_oe; next_aw_h = aw_h; next_w_h = w_h;
      next_wa = wa; next_wd = wd; next_bv = bv; next_wr_bad = wr_bad;
      next_rv = rv; next_rd = rd; next_rr = rr;
      next_sck = sck; next_sd = sd; next_sl = sl; next_pl = pl; next_oe = oe;
      // Write halves in either order
      if (i_awvalid && o_awready)
      begin
         next_aw_h = 1'b1;
         next_wa = i_awaddr;
      end
      if (i_wvalid && o_wready)
      begin
         next_w_h = 1'b1;
         next_wd = i_wdata;
      end
      if (bv && i_bready)
         next_bv = 1'b0;
      if (rv && i_rready)
         next_rv = 1'b0;
      // Sequencer timing
      if (cnt != 4'h0)
         next_cnt = cnt - 4'h1;
      else
         case (st)
            H_PLOW:
            begin
               next_pl = 1'b1;
               next_cnt = 4'(PIN_SH_CYC - 1);
               next_st = H_PHOLD;
            end
            H_PHOLD:
            begin
               next_oe = pin_oe;
               next_st = H_IDLE;
            end
            H_SLOW:
            begin
               next_sck = 1'b1;
               next_cnt = 4'(SCLK_HALF_CYC - 1);
               next_st = H_SHIGH;
            end
            H_SHIGH:
            begin
               next_sck = 1'b0;
               next_cnt = 4'(SCLK_HALF_CYC - 1);
               if (bit_i == 4'h1)
               begin
                  next_sl = 1'b1;
                  next_cnt = 4'(LOAD_PW_CYC - 1);
                  next_st = H_SLOAD;
               end
               else
               begin
                  next_bit_i = bit_i - 4'h1;
                  next_sd = cfg[bit_i - 4'h2];
                  next_st = H_SLOW;
               end
            end
            H_SLOAD:
            begin
               next_sl = 1'b0;
               next_cnt = 4'(LOAD_PW_CYC - 1);
               next_st = H_SEND;
            end
            H_SEND: next_st = H_IDLE;
            default: next_st = H_IDLE;
         endcase
      if (do_wr)
      begin
         next_aw_h = 1'b0;
         next_w_h = 1'b0;
         next_bv = 1'b1;
         next_wr_bad = 1'b0;
         if (wa == REG_CFG && i_wstrb != 4'h0)
            next_cfg = wd[SR_W-1:0];
         else if (wa == REG_PIN)
         begin
            next_pin_oe = wd[PIN_OE_BIT];
            if (st == H_IDLE)
               next_oe = wd[PIN_OE_BIT];
         end
         else if (wa == REG_CMD)
         begin
            if (st == H_IDLE && wd[CMD_PAR_BIT])
            begin
               next_pl = 1'b0;
               next_oe = 1'b1;
               next_cnt = 4'(LOAD_PW_CYC + PIN_SH_CYC - 1);
               next_st = H_PLOW;
            end
            else if (st == H_IDLE && wd[CMD_SER_BIT])
            begin
               next_sd = cfg[SR_W-1];
               next_bit_i = 4'(SR_W);
               next_cnt = 4'(SCLK_HALF_CYC - 1);
               next_st = H_SLOW;
            end
         end
         else if (wa != REG_STAT)
            next_wr_bad = 1'b1;
      end
      if (i_arvalid && o_arready)
      begin
         next_rv = 1'b1;
         next_rr = RESP_OKAY;
         next_rd = 32'h0000_0000;
         case (i_araddr)
            REG_CMD: next_rd = 32'h0000_0000;
            REG_CFG: next_rd[SR_W-1:0] = cfg;
            REG_PIN: next_rd[PIN_OE_BIT] = pin_oe;
            REG_STAT:
            begin
               next_rd[STAT_BUSY_BIT] = (st != H_IDLE);
               next_rd[STAT_PLOAD_BIT] = pl;
            end
            default: next_rr = RESP_SLVERR;
         endcase
      end
   end

   // Registers only; load strobe held low from reset
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         st <= H_IDLE; cnt <= 4'h0; bit_i <= 4'h0;
         cfg <= {T_RST, N_RST, M_RST}; pin_oe <= 1'b0;
         aw_h <= 1'b0; w_h <= 1'b0; wa <= '0; wd <= 32'h0000_0000;
         bv <= 1'b0; wr_bad <= 1'b0; rv <= 1'b0; rd <= 32'h0000_0000; rr <= RESP_OKAY;
         sck <= 1'b0; sd <= 1'b0; sl <= 1'b0; pl <= 1'b0; oe <= 1'b0;
      end
      else if (i_ce)
      begin
         st <= next_st; cnt <= next_cnt; bit_i <= next_bit_i;
         cfg <= next_cfg; pin_oe <= next_pin_oe;
         aw_h <= next_aw_h; w_h <= next_w_h; wa <= next_wa; wd <= next_wd;
         bv <= next_bv; wr_bad <= next_wr_bad; rv <= next_rv; rd <= next_rd; rr <= next_rr;
         sck <= next_sck; sd <= next_sd; sl <= next_sl; pl <= next_pl; oe <= next_oe;
      end
   end

   // Outputs
   assign o_awready = ~aw_h & ~bv;
   assign o_wready = ~w_h & ~bv;
   assign o_bvalid = bv;
   assign o_bresp = wr_bad ? RESP_SLVERR : RESP_OKAY;
   assign o_arready = ~rv;
   assign o_rvalid = rv;
   assign o_rdata = rd;
   assign o_rresp = rr;
   assign link.s_clock = sck;
   assign link.s_data = sd;
   assign link.s_load = sl;
   assign link.p_load_n = pl;
   assign link.par_oe = oe;
   assign link.m_drv = cfg[CFG_M_LSB +: M_W];
   assign link.n_drv = cfg[CFG_N_LSB +: N_W];
endmodule // pdc_host

// [testbench/pdc_checker.sv]
// Concurrent checks on the link between controller and loader
`timescale 1ns/1ps
module pdc_checker
   import pdc_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic s_clock,
   input wire logic s_data,
   input wire logic s_load,
   input wire logic p_load_n,
   input wire logic par_oe,
   input wire logic [M_W-1:0] m_pin,
   input wire logic [N_W-1:0] n_pin
);
   // ***********************
   // Bit counter
   // ***********************
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   logic s_clock_q; // Last shift clock level
   logic [4:0] bits; // Rises since last strobe
   logic [4:0] next_bits;
   // Counts rises; a strobe starts a new frame
   always_comb
   begin
      next_bits = bits;
      if (s_load)
         next_bits = 5'h00;
      else if (s_clock && !s_clock_q)
         next_bits = bits + 5'h01;
   end
   // Registers only
   always_ff @(posedge i_mclk)
   begin
      s_clock_q <= i_rst ? 1'b0 : s_clock;
      bits <= i_rst ? 5'h00 : next_bits;
   end
   property p_pullup;
      !par_oe |-> m_pin == 9'h1FF && n_pin == 2'h3;
   endproperty
   a_pullup: assert property (p_pullup)
      else $error("undriven pin not high");
   property p_par_quiet;
      !p_load_n |-> !s_load;
   endproperty
   a_par_quiet: assert property (p_par_quiet)
      else $error("serial strobe while parallel load low");
   property p_strobe_pw;
      $rose(s_load) |-> s_load[*2] ##1 !s_load;
   endproperty
   a_strobe_pw: assert property (p_strobe_pw)
      else $error("serial strobe width wrong");
   property p_bit_count;
      $rose(s_load) |-> bits == 5'h0E;
   endproperty
   a_bit_count: assert property (p_bit_count)
      else $error("strobe not after fourteen bits");
   property p_sclk_rate;
      $rose(s_clock) |-> s_clock[*2] ##1 !s_clock[*2];
   endproperty
   a_sclk_rate: assert property (p_sclk_rate)
      else $error("shift clock too fast");
   property p_data_hold;
      s_clock |-> $stable(s_data);
   endproperty
   a_data_hold: assert property (p_data_hold)
      else $error("serial data moved while clock high");
   property p_pload_pw;
      $fell(p_load_n) |-> !p_load_n[*3];
   endproperty
   a_pload_pw: assert property (p_pload_pw)
      else $error("parallel load pulse too short");
   property p_pin_hold;
      $rose(p_load_n) |-> par_oe && $stable(m_pin) && $stable(n_pin);
   endproperty
   a_pin_hold: assert property (p_pin_hold)
      else $error("pins moved at parallel capture");
endmodule // pdc_checker

// [testbench/pll_divider_config_loader_test.sv]
// Self-checking bench: controller and loader joined by the link
`timescale 1ns/1ps
module pll_divider_config_loader_test;
   import pdc_pkg::*;
   // ***********************
   // Stimulus and wiring
   // ***********************
   logic i_mclk = 1'b0, i_rst = 1'b1, ce = 1'b1, ref_clk = 1'b0, vco_clk = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awready, wready, bvalid, arready, rvalid, synth, cmp, fb, mon;
   logic [1:0] bresp, rresp, msel = 2'h0;
   logic [31:0] rdata;
   logic [8:0] m_act;
   logic [1:0] n_act;
   logic [2:0] t_act;
   logic [13:0] cfg, prev, sh = 14'h0;
   logic sc_q = 1'b0, sl_q = 1'b0;
   logic [33:0] rq[$]; // Expected read answers
   logic [13:0] sq[$]; // Expected serial frames
   logic [1:0] nsel[4] = '{N_DIV1, N_DIV2, N_DIV4, N_DIV8};
   int ratio[4] = '{1, 2, 4, 8};
   int seed = 87179, miscompares = 0, compares = 0;
   wire mx = (msel == 2'h0) ? synth : (msel == 2'h1) ? fb : cmp;
   // Slow async sources so synchronisers can follow them
   always #12.5 i_mclk = ~i_mclk;
   always #100 ref_clk = ~ref_clk;
   always #250 vco_clk = ~vco_clk;
   pdc_link_if pdc_link_if_inst ();
   pdc_device pdc_device_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(ce),
      .link(pdc_link_if_inst), .i_external_reference_in(ref_clk), .i_vco_clk(vco_clk),
      .o_synth_clock_out(synth), .o_cmp_ref(cmp), .o_fb_ref(fb), .o_monitor(mon),
      .o_m_active(m_act), .o_n_active(n_act), .o_t_active(t_act));
   pdc_host pdc_host_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(ce),
      .link(pdc_link_if_inst), .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
      .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hF),
      .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid),
      .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
      .o_rdata(rdata), .o_rresp(rresp));
   pdc_checker pdc_checker_inst (.i_mclk(i_mclk), .i_rst(i_rst),
      .s_clock(pdc_link_if_inst.s_clock), .s_data(pdc_link_if_inst.s_data),
      .s_load(pdc_link_if_inst.s_load), .p_load_n(pdc_link_if_inst.p_load_n),
      .par_oe(pdc_link_if_inst.par_oe), .m_pin(pdc_link_if_inst.m_pin),
      .n_pin(pdc_link_if_inst.n_pin));
   // ***********************
   // Tasks
   // ***********************
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Write; each half released once taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever
      begin
         @(posedge i_mclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid)
            break;
      end
      bready <= 1'b0;
   endtask
   // Read; answer judged by the watcher below
   task automatic axr(input logic [7:0] a, input logic [33:0] e);
      rq.push_back(e);
      @(posedge i_mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever
      begin
         @(posedge i_mclk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid)
            break;
      end
      rready <= 1'b0;
   endtask
   // Sync jitter allows one clock of error per edge
   function automatic logic near(input real a, input real b);
      return (a - b) < 26.0 && (b - a) < 26.0;
   endfunction
   task automatic period(input logic [1:0] sel, input real e);
      realtime t0;
      realtime th;
      msel = sel;
      @(posedge mx);
      @(posedge mx);
      t0 = $realtime;
      @(negedge mx);
      th = $realtime;
      @(posedge mx);
      check(near($realtime - t0, e), 1'b1);
      check(near(th - t0, e / 2), 1'b1);
   endtask
   // Read answers and wire frames against notes
   always @(posedge i_mclk)
   begin
      sc_q <= pdc_link_if_inst.s_clock;
      sl_q <= pdc_link_if_inst.s_load;
      if (rvalid && rready)
         check({rresp, rdata}, rq.pop_front());
      if (pdc_link_if_inst.s_clock && !sc_q)
         sh <= {sh[12:0], pdc_link_if_inst.s_data};
      if (pdc_link_if_inst.s_load && !sl_q)
         check(sh, sq.pop_front());
   end
   // Hang guard, well past the expected run
   initial
   begin
      #400_000;
      miscompares++;
      results();
   end
   // ***********************
   // Main sequence
   // ***********************
   initial
   begin
      repeat (2) @(posedge i_mclk);
      i_rst <= 1'b0;
      @(negedge i_mclk);
      check({t_act, n_act, m_act}, {T_RST, N_RST, M_RST});
      check(mon, 1'b0);
      check(pdc_link_if_inst.p_load_n, 1'b0);
      axr(REG_CFG, {RESP_OKAY, 32'h7FF});
      axr(8'h10, {RESP_SLVERR, 32'h0});
      period(2'h2, 3200.0);
      // Every ratio code through the pins
      for (int i = 0; i < 4; i++)
      begin
         prev = {3'h0, nsel[i], 9'(3 + i)};
         axw(REG_CFG, {18'h0, 3'h5, prev[10:0]});
         axw(REG_CMD, 32'h2);
         repeat (12) @(posedge i_mclk);
         @(negedge i_mclk);
         check({t_act, n_act, m_act}, prev);
         period(2'h0, 500.0 * ratio[i]);
         period(2'h1, 1000.0 * (3 + i));
      end
      // Random frames over the serial link
      for (int i = 0; i < 3; i++)
      begin
         cfg = 14'($random(seed));
         // Keep M inside the lock range
         cfg[8:0] = 9'(200 + {$random(seed)} % 201);
         sq.push_back(cfg);
         axw(REG_CFG, {18'h0, cfg});
         axw(REG_CMD, 32'h1);
         repeat (30) @(posedge i_mclk);
         @(negedge i_mclk);
         check({t_act, n_act, m_act}, prev);
         repeat (60) @(posedge i_mclk);
         @(negedge i_mclk);
         check({t_act, n_act, m_act}, cfg);
         prev = cfg;
      end
      // Both commands at once: pins win, T cleared
      axw(REG_CFG, {18'h0, 3'h7, N_DIV2, 9'h0AA});
      axw(REG_CMD, 32'h3);
      repeat (100) @(posedge i_mclk);
      @(negedge i_mclk);
      check({t_act, n_act, m_act}, {3'h0, N_DIV2, 9'h0AA});
      check(mon, 1'b0);
      results();
   end
endmodule // pll_divider_config_loader_test
